// ---- dcws_defines.svh ----
`ifndef DCWS_DEFINES_SVH
`define DCWS_DEFINES_SVH
// Contract
// - Mode pin high gives duty-cycle mode waking about every 300 ms.
// - Mode pin low keeps the receiver on; the duty cycle never powers it down.
// - A wake-up event starts the oscillator, then waits 2.25 ms to settle.
// - When the oscillator is stable, the synthesizer turns on and listening starts.
// - Limit select zero gives -103dBm, one gives -97dBm.
// - Strength above the limit within 6ms extends the on-period to 30.5ms.
// - No strength above the limit switches the synthesizer off after 6ms.
// - Every sync word restarts the on-state timer.
// - Busy pattern recognition keeps the synthesizer on until data is done.
// - The measured frequency offset is reported in the status word.
// - Load capacitance is settable from 8.5 pF to 16 pF in 0.5 pF steps.
// - Frequency control corrects offsets up to 80% of the deviation; here afcEnable is unused and afcOffset is only reported, not corrected.
// - The status offset field is meant to be added to the frequency word.
// - The strength flag is high while strength is above the limit.
`define DCWS_CLK_HZ 50000000
`define DCWS_PERIOD_US 300000
`define DCWS_SETTLE_US 2250
`define DCWS_LISTEN_US 6000
`define DCWS_EXTEND_US 30500
`define DCWS_US2CYC(us) ((us) * (`DCWS_CLK_HZ / 1000000))
`define DCWS_LIMIT_LO_DBM (-103)
`define DCWS_LIMIT_HI_DBM (-97)
`define DCWS_CAP_MIN_TENTH_PF 85
`define DCWS_CAP_STEP_TENTH_PF 5
`define DCWS_CAP_MAX_CODE 4'hf
`define DCWS_AFC_PCT 80
`define DCWS_OSC_RST 1'b1
`define DCWS_SYN_RST 1'b1
`define DCWS_CAP_RST 4'h0
`endif

// ---- dcws_duty_cycle_wake_sequencer_tb.sv ----
`timescale 1ns/10ps
module dcws_duty_cycle_wake_sequencer_tb;
    import dcws_pkg::*;
    localparam int P = 200, S = 10, L = 20, E = 40;
    logic sys_clk = 0, arst_n = 0, mode = 0, sel = 0, sync = 0, busy = 0;
    logic afcEn = 1, clkEn = 1;
    logic [5:0] offs = 6'h00;
    logic [3:0] cap = 4'h0, capOut;
    logic signed [7:0] level = 8'h88, strength;
    logic oscEnable, synthEnable, wakeEvent;
    dcws_status_type status;
    int err_count = 0, total_checks = 0, gap;
    always #10 sys_clk = ~sys_clk;
    dcws_duty_cycle_wake_sequencer #(.PERIOD_CYC(P), .SETTLE_CYC(S),
        .LISTEN_CYC(L), .EXTEND_CYC(E)) dut (.sys_clk(sys_clk),
        .arst_n(arst_n), .clkEn(clkEn), .low_power_duty_mode(mode),
        .rssi_limit_select(sel), .signalStrengthDbm(strength),
        .syncDetect(sync), .patternBusy(busy), .afcEnable(afcEn),
        .afcOffset(offs), .loadCapCode(cap), .oscEnable(oscEnable),
        .synthEnable(synthEnable), .wakeEvent(wakeEvent),
        .status(status), .loadCapSetting(capOut));
    dcws_radio_model radio (.sys_clk(sys_clk), .synthEnable(synthEnable),
        .level(level), .strength(strength));
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", what, e, g);
        end
    endtask : chk
    task automatic chkb(input string what, input logic e, input logic g);
        chk(what, {7'h00, e}, {7'h00, g});
    endtask : chkb
    task automatic waitWake(output int n);
        n = 0;
        while (wakeEvent !== 1'b1) begin
            tick(1);
            n++;
            if (n > 2 * P) begin
                err_count++;
                final_report();
            end
        end
    endtask : waitWake
    initial begin
        tick(2);
        chkb("osc", 1'b1, oscEnable);
        chkb("synth", 1'b1, synthEnable);
        chkb("wake", 1'b0, wakeEvent);
        tick(2);
        arst_n = 1;
        for (int i = 0; i < 4; i++) begin
            sel = i[1];
            level = i[0] ? 8'h9f : 8'h9c;
            afcEn = 0;
            offs = 6'(i * 13 + 5);
            cap = 4'(i * 5);
            tick(6);
            chkb("flag", ~i[1], status.signalFlag);
            chk("offset", {2'h0, offs}, {2'h0, status.measuredOffsetField});
            chk("cap", {4'h0, cap}, {4'h0, capOut});
        end
        clkEn = 0;
        offs = 6'h3f;
        cap = 4'ha;
        tick(4);
        chk("frozen offset", 8'h2c, {2'h0, status.measuredOffsetField});
        chk("frozen cap", 8'h0f, {4'h0, capOut});
        clkEn = 1;
        tick(2);
        chk("offset", 8'h3f, {2'h0, status.measuredOffsetField});
        chk("cap", 8'h0a, {4'h0, capOut});
        level = 8'h88;
        sel = 0;
        mode = 1;
        waitWake(gap);
        chkb("osc", 1'b1, oscEnable);
        tick(S - 2);
        chkb("synth", 1'b0, synthEnable);
        tick(4);
        chkb("synth", 1'b1, synthEnable);
        tick(L - 6);
        chkb("synth", 1'b1, synthEnable);
        tick(8);
        chkb("synth", 1'b0, synthEnable);
        chkb("osc", 1'b0, oscEnable);
        level = 8'ha6;
        tick(1);
        waitWake(gap);
        chk("period", 8'hc8, 8'(S + L + 5 + gap));
        tick(S + L + 4);
        chkb("synth", 1'b1, synthEnable);
        sync = 1;
        tick(1);
        sync = 0;
        tick(36);
        chkb("synth", 1'b1, synthEnable);
        tick(10);
        chkb("synth", 1'b0, synthEnable);
        tick(1);
        waitWake(gap);
        tick(S + 5);
        busy = 1;
        tick(E + L + 10);
        chkb("synth", 1'b1, synthEnable);
        busy = 0;
        tick(4);
        chkb("synth", 1'b0, synthEnable);
        level = 8'h88;
        tick(1);
        waitWake(gap);
        tick(S + 5);
        sync = 1;
        tick(1);
        sync = 0;
        tick(30);
        chkb("synth", 1'b1, synthEnable);
        tick(12);
        chkb("synth", 1'b0, synthEnable);
        mode = 0;
        tick(P + 10);
        chkb("synth", 1'b1, synthEnable);
        chkb("osc", 1'b1, oscEnable);
        final_report();
    end
endmodule : dcws_duty_cycle_wake_sequencer_tb

// ---- dcws_pkg.sv ----
package dcws_pkg;
    typedef enum logic [4:0] {
        ST_CONT = 5'h01,
        ST_SLEEP = 5'h02,
        ST_SETTLE = 5'h04,
        ST_LISTEN = 5'h08,
        ST_EXTEND = 5'h10
    } dcws_state_type;
    typedef struct packed {
        logic signalFlag;
        logic [5:0] measuredOffsetField;
    } dcws_status_type;
endpackage : dcws_pkg

// ---- dcws_radio_model.sv ----
`timescale 1ns/10ps
module dcws_radio_model (
    input wire logic sys_clk,
    input wire logic synthEnable,
    input wire logic signed [7:0] level,
    output logic signed [7:0] strength
);
    // Synthesizer off means nothing is received, so report the floor
    always_ff @(posedge sys_clk) begin
        strength <= synthEnable ? level : 8'h80;
    end
endmodule : dcws_radio_model

// ---- duty_cycle_wake_sequencer.sv ----
`timescale 1ns/10ps
`include "dcws_defines.svh"
module dcws_duty_cycle_wake_sequencer #(
    parameter int PERIOD_CYC = `DCWS_US2CYC(`DCWS_PERIOD_US),
    parameter int SETTLE_CYC = `DCWS_US2CYC(`DCWS_SETTLE_US),
    parameter int LISTEN_CYC = `DCWS_US2CYC(`DCWS_LISTEN_US),
    parameter int EXTEND_CYC = `DCWS_US2CYC(`DCWS_EXTEND_US)
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic low_power_duty_mode,
    input wire logic rssi_limit_select,
    input wire logic signed [7:0] signalStrengthDbm,
    input wire logic syncDetect,
    input wire logic patternBusy,
    input wire logic afcEnable,
    input wire logic [5:0] afcOffset,
    input wire logic [3:0] loadCapCode,
    output logic oscEnable,
    output logic synthEnable,
    output logic wakeEvent,
    output dcws_pkg::dcws_status_type status,
    output logic [3:0] loadCapSetting
);
    import dcws_pkg::*;

    localparam logic signed [7:0] LIMIT_LO = 8'(`DCWS_LIMIT_LO_DBM);
    localparam logic signed [7:0] LIMIT_HI = 8'(`DCWS_LIMIT_HI_DBM);

    // Mode and limit select pins pass two flops; the first stage is read only by the second
    logic [1:0] modeSync_r;
    logic [1:0] modeSync_nxt;
    logic [1:0] selSync_r;
    logic [1:0] selSync_nxt;
    logic modeDuty;
    logic limitHigh;
    logic above;

    logic [24:0] phase_r;
    logic [24:0] phase_nxt;
    logic phaseWrap;

    dcws_state_type state_r;
    dcws_state_type state_nxt;
    logic [24:0] tmr_r;
    logic [24:0] tmr_nxt;
    logic tmrDone;
    logic osc_r;
    logic osc_nxt;
    logic syn_r;
    logic syn_nxt;
    logic wake_r;
    logic wake_nxt;

    dcws_status_type stat_r;
    dcws_status_type stat_nxt;
    logic [3:0] cap_r;
    logic [3:0] cap_nxt;

    // Timer reload value; the timer hits zero on the last cycle of a span
    function automatic logic [24:0] cyc(input int n);
        cyc = 25'(n - 1);
    endfunction : cyc

    // Strictly above the limit; equal strength does not count
    function automatic logic aboveLimit(input logic signed [7:0] dbm,
                                        input logic high);
        aboveLimit = high ? (dbm > LIMIT_HI) : (dbm > LIMIT_LO);
    endfunction : aboveLimit

    function automatic logic synthOn(input dcws_state_type s);
        synthOn = (s == ST_CONT) || (s == ST_LISTEN) || (s == ST_EXTEND);
    endfunction : synthOn

    function automatic logic onPeriod(input dcws_state_type s);
        onPeriod = (s == ST_LISTEN) || (s == ST_EXTEND);
    endfunction : onPeriod

    always_comb begin
        modeSync_nxt = {modeSync_r[0], low_power_duty_mode};
        selSync_nxt = {selSync_r[0], rssi_limit_select};
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            modeSync_r <= 2'h0;
            selSync_r <= 2'h0;
        end else if (clkEn) begin
            modeSync_r <= modeSync_nxt;
            selSync_r <= selSync_nxt;
        end
    end

    assign modeDuty = modeSync_r[1];
    assign limitHigh = selSync_r[1];
    // Strength is already on this clock, so it is compared unsynchronised
    assign above = aboveLimit(signalStrengthDbm, limitHigh);

    // Wake-up timer free runs so the period does not drift with activity
    always_comb begin
        phaseWrap = (phase_r == cyc(PERIOD_CYC));
        phase_nxt = phaseWrap ? 25'h0 : phase_r + 25'h1;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_r <= 25'h0;
        end else if (clkEn) begin
            phase_r <= phase_nxt;
        end
    end

    assign tmrDone = (tmr_r == 25'h0);

    always_comb begin
        state_nxt = state_r;
        tmr_nxt = tmrDone ? tmr_r : tmr_r - 25'h1;
        wake_nxt = 1'b0;
        case (state_r)
            ST_CONT: begin
                if (modeDuty) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!modeDuty) begin
                    state_nxt = ST_CONT;
                end else if (phase_r == 25'h0) begin
                    wake_nxt = 1'b1;
                    tmr_nxt = cyc(SETTLE_CYC);
                    state_nxt = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (tmrDone) begin
                    tmr_nxt = cyc(LISTEN_CYC);
                    state_nxt = ST_LISTEN;
                end
            end
            ST_LISTEN, ST_EXTEND: begin
                if (syncDetect) begin
                    tmr_nxt = cyc(EXTEND_CYC);
                    state_nxt = ST_EXTEND;
                end else if (state_r == ST_LISTEN && above) begin
                    tmr_nxt = cyc(EXTEND_CYC);
                    state_nxt = ST_EXTEND;
                end else if (tmrDone && !patternBusy) begin
                    // Mode low here waits for the period to end first
                    state_nxt = modeDuty ? ST_SLEEP : ST_CONT;
                end
            end
            default: begin
                state_nxt = ST_CONT;
            end
        endcase
        // Powers follow the next state so they change with it, not after
        osc_nxt = (state_nxt != ST_SLEEP);
        syn_nxt = synthOn(state_nxt);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_CONT;
            tmr_r <= 25'h0;
            osc_r <= `DCWS_OSC_RST;
            syn_r <= `DCWS_SYN_RST;
            wake_r <= 1'b0;
        end else if (clkEn) begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            osc_r <= osc_nxt;
            syn_r <= syn_nxt;
            wake_r <= wake_nxt;
        end
    end

    always_comb begin
        stat_nxt.signalFlag = above;
        // Offset only trusted by the host with AFC off; exposed as measured
        stat_nxt.measuredOffsetField = afcOffset;
        cap_nxt = loadCapCode;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_r <= '0;
            cap_r <= `DCWS_CAP_RST;
        end else if (clkEn) begin
            stat_r <= stat_nxt;
            cap_r <= cap_nxt;
        end
    end

    assign oscEnable = osc_r;
    assign synthEnable = syn_r;
    assign wakeEvent = wake_r;
    assign status = stat_r;
    assign loadCapSetting = cap_r;

    // Checks below watch the registered outputs against the sequence
    a_cont_on: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        state_r == ST_CONT |-> syn_r && osc_r)
        else $error("continuous mode lost synth");

    a_sleep_off: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        state_r == ST_SLEEP |-> !osc_r && !syn_r)
        else $error("sleep left power on");

    a_wake_osc: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        wake_r |-> osc_r && !syn_r && state_r == ST_SETTLE)
        else $error("wake did not start oscillator");

    a_settle_syn: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        state_r == ST_SETTLE && tmrDone && clkEn
        |=> state_r == ST_LISTEN && syn_r)
        else $error("synth not on after settle");

    a_extend_load: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && state_r == ST_LISTEN && above
        |=> state_r == ST_EXTEND && tmr_r == cyc(EXTEND_CYC))
        else $error("extension not loaded");

    a_sync_restart: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && syncDetect && onPeriod(state_r)
        |=> tmr_r == cyc(EXTEND_CYC))
        else $error("sync did not restart timer");

    a_busy_hold: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        patternBusy && onPeriod(state_r) |=> syn_r)
        else $error("synth off while pattern busy");

    a_listen_end: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && state_r == ST_LISTEN && tmrDone && !above
        && !syncDetect && !patternBusy && modeDuty
        |=> state_r == ST_SLEEP && !syn_r)
        else $error("listen did not end");

    a_flag_track: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn |=> stat_r.signalFlag == $past(above))
        else $error("strength flag wrong");

    a_wake_phase: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && state_r == ST_SLEEP && modeDuty && phase_r == 25'h0
        |=> wake_r && state_r == ST_SETTLE)
        else $error("no wake at timer event");

    a_wake_pulse: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && wake_r |=> !wake_r)
        else $error("wake pulse too long");

    a_settle_load: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        wake_r |-> tmr_r == cyc(SETTLE_CYC))
        else $error("settle time not loaded");

    a_mode_cont: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && !modeDuty && state_r == ST_SLEEP
        |=> state_r == ST_CONT && syn_r && osc_r)
        else $error("mode low did not wake receiver");

    a_cont_stay: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && !modeDuty && state_r == ST_CONT |=> state_r == ST_CONT)
        else $error("continuous mode left");

    a_listen_hold: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && state_r == ST_LISTEN && !tmrDone |=> syn_r)
        else $error("synth off inside listen window");

    a_extend_end: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && state_r == ST_EXTEND && tmrDone && !syncDetect
        && !patternBusy && modeDuty
        |=> state_r == ST_SLEEP && !osc_r && !syn_r)
        else $error("extension did not power down");

    a_limit_edge: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && limitHigh && signalStrengthDbm == LIMIT_HI
        |=> !status.signalFlag)
        else $error("flag set at the high limit");

    a_limit_low: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn && !limitHigh && signalStrengthDbm == LIMIT_HI
        |=> status.signalFlag)
        else $error("flag clear above the low limit");

    a_offset_copy: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn |=> status.measuredOffsetField == $past(afcOffset))
        else $error("offset field wrong");

    a_cap_copy: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clkEn |=> loadCapSetting == $past(loadCapCode))
        else $error("load capacitance wrong");

    a_clk_freeze: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        !clkEn |=> $stable(state_r) && $stable(tmr_r) && $stable(phase_r))
        else $error("state moved with clock enable low");
endmodule : dcws_duty_cycle_wake_sequencer
